// ### design/rscg_device.sv
// receiver end: serial setup registers, readback and gain word
//
// Strobed register access and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
module rscg_device #(
  parameter logic [7:0] DEVICE_ID = 8'h5A // arbitrary identification value
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // serial link
  rscg_link_if.device_mp link,
  // fast gain pins, asynchronous
  input wire logic fast_gain_pin_msb_i,
  input wire logic fast_gain_pin_mid_i,
  input wire logic fast_gain_pin_lsb_i,
  // offset DAC codes from calibration
  input wire logic [7:0] dac_i_code_i,
  input wire logic [7:0] dac_q_code_i,
  // setup outputs
  output logic [4:0] baseband_gain_word_o,
  output logic detector_resistor_bypass_o,
  output logic detector_capacitor_bypass_o,
  output logic [31:0] setup_reg1_o,
  output logic [31:0] setup_reg2_o,
  output logic [31:0] setup_reg3_o,
  output logic [31:0] setup_reg5_o,
  output logic readback_mode_o
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0] sclk_p;   // [0] first stage, [1] second, [2] delayed
    logic [1:0] data_p;
    logic [2:0] strobe_p;
    logic [2:0] pins_s1;
    logic [2:0] pins_s2;
    logic [31:0] shift;
    logic [31:0] r1;
    logic [31:0] r2;
    logic [31:0] r3;
    logic [31:0] r5;
    logic rb_mode;
    logic [31:0] rb_word;
    logic [5:0] rb_cnt;
    logic rb_out;
    logic [4:0] gain;
  } rscg_dev_state_t;

  rscg_dev_state_t state_reg;
  rscg_dev_state_t state_next;

  logic sclk_rise;
  logic strobe_rise;
  logic [1:0] addr;
  logic [2:0] rb_sel;
  logic [31:0] reg0_word;
  logic [3:0] reduction;
  logic [4:0] prog_gain;

  // ----------------------------------------------------------------
  // edge detection on synchronised link pins
  // ----------------------------------------------------------------
  // edges look only at second and delayed stages, never the first
  assign sclk_rise = state_reg.sclk_p[1] & ~state_reg.sclk_p[2]; // [R2]
  assign strobe_rise = state_reg.strobe_p[1] & ~state_reg.strobe_p[2]; // [R3]

  // field decode of the committed word
  assign addr = state_reg.shift[rscg_pkg::ADDR_LSB +: 2]; // [R4]
  assign rb_sel = state_reg.shift[rscg_pkg::RB_SEL_LSB +: rscg_pkg::RB_SEL_W];

  // read-only identity and offset DAC word
  always_comb
  begin
    reg0_word = 32'h0;
    reg0_word[rscg_pkg::ID_LSB +: rscg_pkg::DAC_W] = DEVICE_ID; // [R11]
    reg0_word[rscg_pkg::DACI_LSB +: rscg_pkg::DAC_W] = dac_i_code_i; // [R5]
    reg0_word[rscg_pkg::DACQ_LSB +: rscg_pkg::DAC_W] = dac_q_code_i;
  end

  // ----------------------------------------------------------------
  // fast gain reduction
  // ----------------------------------------------------------------
  // pins read as a binary step count, msb worth four steps
  always_comb
  begin
    reduction = {1'b0, state_reg.pins_s2}; // [R19]
    if (state_reg.r1[rscg_pkg::FAST_MULT_BIT])
    begin
      reduction = {state_reg.pins_s2, 1'b0}; // [R16]
    end
  end

  assign prog_gain = state_reg.r1[rscg_pkg::GAIN_LSB +: rscg_pkg::GAIN_W]; // [R14]

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    state_next = state_reg;
    // two-stage synchronisers for the link and fast gain pins; dac codes are used as they come
    state_next.sclk_p = {state_reg.sclk_p[1:0], link.serial_clk};
    state_next.data_p = {state_reg.data_p[0], link.serial_data};
    state_next.strobe_p = {state_reg.strobe_p[1:0], link.latch_enable_in};
    state_next.pins_s1 = {fast_gain_pin_msb_i, fast_gain_pin_mid_i, fast_gain_pin_lsb_i};
    state_next.pins_s2 = state_reg.pins_s1;

    // gain follows the pins within a few cycles, no serial access needed
    if (reduction >= {1'b0, prog_gain})
    begin
      state_next.gain = 5'h00; // [R17]
    end
    else
    begin
      state_next.gain = prog_gain - {1'b0, reduction}; // [R15] [R17]
    end

    if (strobe_rise)
    begin
      // strobe ends any readback in progress and commits the word
      state_next.rb_mode = 1'b0;
      state_next.rb_out = 1'b0;
      case (addr) // [R4]
        2'h1:
        begin
          state_next.r1 = state_reg.shift; // [R3]
        end
        2'h2:
        begin
          state_next.r2 = state_reg.shift;
        end
        2'h3:
        begin
          state_next.r3 = state_reg.shift;
        end
        default:
        begin
          if (state_reg.shift[rscg_pkg::RB_FLAG_BIT])
          begin
            // readback command: latch the selected word now, so a later
            // write cannot tear the value being shifted out
            state_next.rb_mode = 1'b1; // [R7]
            state_next.rb_cnt = 6'h00;
            case (rb_sel) // [R5]
              rscg_pkg::SEL_REG0: state_next.rb_word = reg0_word;
              rscg_pkg::SEL_REG1: state_next.rb_word = state_reg.r1;
              rscg_pkg::SEL_REG2: state_next.rb_word = state_reg.r2;
              rscg_pkg::SEL_REG3: state_next.rb_word = state_reg.r3;
              rscg_pkg::SEL_REG5: state_next.rb_word = state_reg.r5;
              default: state_next.rb_word = 32'h0;
            endcase
          end
          else if (state_reg.shift[rscg_pkg::EXT_SEL_BIT])
          begin
            state_next.r5 = state_reg.shift;
          end
          // register 4 and any write to register 0 are dropped
          // [R10] [R11]
        end
      endcase
    end
    else if (sclk_rise)
    begin
      // shift in: first bit ends in position 0 after 32 clocks
      state_next.shift = {state_reg.data_p[1], state_reg.shift[31:1]}; // [R1] [R2]
      if (state_reg.rb_mode)
      begin
        if (state_reg.rb_cnt < rscg_pkg::RB_IDLE_PULSES)
        begin
          state_next.rb_cnt = state_reg.rb_cnt + 6'h01; // [R9]
        end
        else
        begin
          // next bit out on the rise, controller samples on the fall
          state_next.rb_out = state_reg.rb_word[0]; // [R8]
          state_next.rb_word = {1'b0, state_reg.rb_word[31:1]};
          state_next.rb_cnt = state_reg.rb_cnt + 6'h01;
          if (state_reg.rb_cnt == rscg_pkg::RB_LAST_PULSE)
          begin
            state_next.rb_mode = 1'b0; // [R9]
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      state_reg <= '0;
      state_reg.r1 <= rscg_pkg::SETUP_RST;
      state_reg.r2 <= rscg_pkg::SETUP_RST;
      state_reg.r3 <= rscg_pkg::SETUP_RST; // mixer load bits start at 0 [R13]
      state_reg.r5 <= rscg_pkg::SETUP_RST;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign link.readback_data = state_reg.rb_out;
  assign baseband_gain_word_o = state_reg.gain;
  assign detector_resistor_bypass_o = state_reg.r1[rscg_pkg::RES_BYP_BIT]; // [R12]
  assign detector_capacitor_bypass_o = state_reg.r1[rscg_pkg::CAP_BYP_BIT]; // [R12]
  assign setup_reg1_o = state_reg.r1;
  assign setup_reg2_o = state_reg.r2;
  assign setup_reg3_o = state_reg.r3;
  assign setup_reg5_o = state_reg.r5;
  assign readback_mode_o = state_reg.rb_mode;

endmodule : rscg_device

// ### design/rscg_pkg.sv
// shared constants for the receiver serial control and gain link
// ----------------------------------------------------------------
// Notes on behaviour
// R1 - device holds a 32-bit serial shift register
// R2 - bits LSB first, sampled on clock rise
// R3 - latch strobe rise commits the shifted word
// R4 - bits 0 and 1 select the target register
// R5 - readback covers setup and offset DAC registers
// R6 - readback is command write, then read transfer
// R7 - command word sets readback mode and selection
// R8 - readback bit driven on rise, sampled on fall
// R9 - first clock idle, next 32 shift out
// R10 - register 4 unused, writes may be ignored
// R11 - register 0 read-only: DAC codes and ID
// R12 - two bits bypass detector resistor and capacitor
// R13 - mixer load adjustment bits left at zero
// R14 - five-bit gain field, register 1 bits 16:12
// R15 - three pins reduce gain without reprogramming
// R16 - register 1 bit 28 doubles pin step
// R17 - effective gain is difference, saturating at zero
// R18 - serial gain programmed only from 0 to 24; the device does not clamp, all 32 field codes pass through
// R19 - pins are binary count, msb weighs four
// ----------------------------------------------------------------
package rscg_pkg;
  // ----------------------------------------------------------------
  // serial word layout
  // ----------------------------------------------------------------
  localparam int WORD_W = 32;
  localparam int ADDR_LSB = 0;
  localparam logic [1:0] ADDR_EXT = 2'h0;
  localparam int RB_FLAG_BIT = 2;
  localparam int EXT_SEL_BIT = 3;
  localparam int RB_SEL_LSB = 3;
  localparam int RB_SEL_W = 3;
  localparam logic [2:0] SEL_REG0 = 3'h0;
  localparam logic [2:0] SEL_REG1 = 3'h1;
  localparam logic [2:0] SEL_REG2 = 3'h2;
  localparam logic [2:0] SEL_REG3 = 3'h3;
  localparam logic [2:0] SEL_REG5 = 3'h5;
  localparam logic [31:0] SETUP_RST = 32'h0;
  // register 1 fields
  localparam int GAIN_LSB = 12;
  localparam int GAIN_W = 5;
  localparam logic [4:0] GAIN_MAX = 5'h18;
  localparam int RES_BYP_BIT = 25;
  localparam int CAP_BYP_BIT = 26;
  localparam int FAST_MULT_BIT = 28;
  // register 0 fields
  localparam int ID_LSB = 0;
  localparam int DACI_LSB = 8;
  localparam int DACQ_LSB = 16;
  localparam int DAC_W = 8;
  // readback sequence: one idle pulse, then the word
  localparam logic [5:0] RB_IDLE_PULSES = 6'h01;
  localparam logic [5:0] RB_LAST_PULSE = 6'h20;
  // ----------------------------------------------------------------
  // host register port and link timing
  // ----------------------------------------------------------------
  localparam logic [3:0] HOST_TX_OFS = 4'h0;
  localparam logic [3:0] HOST_RB_OFS = 4'h4;
  localparam logic [3:0] HOST_STAT_OFS = 4'h8;
  localparam logic [3:0] HOST_RX_OFS = 4'hC;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_RXV_BIT = 1;
  localparam int CLK_PERIOD_NS = 50;
  localparam int SCLK_HALF_NS = 400;
  localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage : rscg_pkg

// ### design/rscg_link_if.sv
// three-wire programming link plus readback line
`timescale 1ns/10ps
interface rscg_link_if;
  logic serial_clk;
  logic serial_data;
  logic latch_enable_in;
  logic readback_data;

  // controller end drives clock, data and strobe
  modport host_mp (
    output serial_clk,
    output serial_data,
    output latch_enable_in,
    input readback_data
  );

  // receiver end drives only the readback line
  modport device_mp (
    input serial_clk,
    input serial_data,
    input latch_enable_in,
    output readback_data
  );
endinterface : rscg_link_if

// ### design/rscg_host.sv
// controller end: register port driving the three-wire link
`timescale 1ns/10ps
module rscg_host #(
  parameter int HALF_CYC = rscg_pkg::SCLK_HALF_CYC
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // software register port
  input wire logic [3:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  // serial link
  rscg_link_if.host_mp link
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    H_IDLE,
    H_SHIFT,
    H_LATCH,
    H_READ
  } rscg_host_st_t;

  typedef struct packed {
    rscg_host_st_t st;
    logic [7:0] div;
    logic [5:0] bitn;
    logic sclk;
    logic sdata;
    logic strobe;
    logic [31:0] word;
    logic rb_pending;
    logic [31:0] rx;
    logic rx_valid;
    logic [1:0] rb_s;
    logic [31:0] rdata;
  } rscg_host_state_t;

  rscg_host_state_t state_reg;
  rscg_host_state_t state_next;
  logic wrap;

  // half period of the serial clock, made by dividing clk_i
  assign wrap = (state_reg.div == 8'(HALF_CYC - 1));

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    state_next = state_reg;
    state_next.rb_s = {state_reg.rb_s[0], link.readback_data};
    state_next.rdata = 32'h0;
    state_next.div = wrap ? 8'h00 : state_reg.div + 8'h01;

    // read data valid only in the cycle after the strobe
    if (rd_i)
    begin
      case (addr_i)
        rscg_pkg::HOST_STAT_OFS:
        begin
          state_next.rdata[rscg_pkg::STAT_BUSY_BIT] = (state_reg.st != H_IDLE);
          state_next.rdata[rscg_pkg::STAT_RXV_BIT] = state_reg.rx_valid;
        end
        rscg_pkg::HOST_RX_OFS: state_next.rdata = state_reg.rx;
        default: state_next.rdata = 32'h0;
      endcase
    end

    case (state_reg.st)
      H_IDLE:
      begin
        // writes while busy are dropped; software polls status first
        if (wr_i && (addr_i == rscg_pkg::HOST_TX_OFS || addr_i == rscg_pkg::HOST_RB_OFS))
        begin
          state_next.st = H_SHIFT;
          state_next.word = wdata_i;
          state_next.sdata = wdata_i[0]; // [R2]
          state_next.div = 8'h00;
          state_next.bitn = 6'h00;
          state_next.rb_pending = (addr_i == rscg_pkg::HOST_RB_OFS); // [R6]
          if (addr_i == rscg_pkg::HOST_RB_OFS)
          begin
            state_next.rx_valid = 1'b0;
          end
        end
      end
      H_SHIFT:
      begin
        if (wrap)
        begin
          state_next.sclk = ~state_reg.sclk;
          if (state_reg.sclk)
          begin
            // data changes on the fall, well clear of the sampling rise
            state_next.word = {1'b0, state_reg.word[31:1]};
            state_next.sdata = state_reg.word[1]; // [R2]
            state_next.bitn = state_reg.bitn + 6'h01;
            if (state_reg.bitn == 6'(rscg_pkg::WORD_W - 1))
            begin
              state_next.st = H_LATCH;
              state_next.sdata = 1'b0;
            end
          end
        end
      end
      H_LATCH:
      begin
        // half period low, half period high on the strobe
        if (wrap)
        begin
          state_next.strobe = ~state_reg.strobe; // [R3]
          if (state_reg.strobe)
          begin
            state_next.st = state_reg.rb_pending ? H_READ : H_IDLE; // [R6]
            state_next.rb_pending = 1'b0;
            state_next.bitn = 6'h00;
          end
        end
      end
      H_READ:
      begin
        if (wrap)
        begin
          state_next.sclk = ~state_reg.sclk;
          if (state_reg.sclk)
          begin
            state_next.bitn = state_reg.bitn + 6'h01;
            if (state_reg.bitn >= rscg_pkg::RB_IDLE_PULSES)
            begin
              // sample on the fall; the first pulse carries nothing
              state_next.rx = {state_reg.rb_s[1], state_reg.rx[31:1]}; // [R8] [R9]
            end
            if (state_reg.bitn == rscg_pkg::RB_LAST_PULSE)
            begin
              state_next.st = H_IDLE;
              state_next.rx_valid = 1'b1;
            end
          end
        end
      end
      default:
      begin
        state_next.st = H_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      state_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign link.serial_clk = state_reg.sclk;
  assign link.serial_data = state_reg.sdata;
  assign link.latch_enable_in = state_reg.strobe;
  assign rdata_o = state_reg.rdata;

endmodule : rscg_host

// ### tb/rscg_assertions.sv
// link checker for the three-wire programming port
`timescale 1ns/10ps
module rscg_assertions (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // link wires
  input wire logic serial_clk,
  input wire logic serial_data,
  input wire logic latch_enable_in,
  input wire logic readback_data
);
  // ----------------------------------------------------------------
  // shadow of the link
  // ----------------------------------------------------------------
  logic sclk_reg;
  logic strobe_reg;
  logic rb_reg;
  logic known_reg;
  logic [5:0] cnt_reg;
  logic [31:0] sr_reg;
  logic [31:0] word_reg;
  logic [31:0] shadow_reg [8];
  wire rise = serial_clk & ~sclk_reg;
  wire fall = sclk_reg & ~serial_clk;
  wire commit = latch_enable_in & ~strobe_reg;
  wire [2:0] sel = sr_reg[5:3];

  // words rebuilt from the wire, so readback can be judged bit by bit
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      sclk_reg <= 1'b0;
      strobe_reg <= 1'b0;
      rb_reg <= 1'b0;
      known_reg <= 1'b0;
      cnt_reg <= 6'h00;
      sr_reg <= 32'h0;
      word_reg <= 32'h0;
      for (int i = 0; i < 8; i++)
        shadow_reg[i] <= 32'h0;
    end
    else
    begin
      sclk_reg <= serial_clk;
      strobe_reg <= latch_enable_in;
      if (rise)
      begin
        sr_reg <= {serial_data, sr_reg[31:1]};
        cnt_reg <= cnt_reg + 6'h01;
      end
      // read phase ends after its last pulse, no strobe follows it
      if (rb_reg && fall && cnt_reg == 6'h21)
      begin
        rb_reg <= 1'b0;
        cnt_reg <= 6'h00;
      end
      if (commit)
      begin
        cnt_reg <= 6'h00;
        rb_reg <= sr_reg[1:0] == 2'h0 && sr_reg[2];
        word_reg <= shadow_reg[sel];
        known_reg <= sel != 3'h0; // dac codes are not visible here
        if (sr_reg[1:0] != 2'h0)
          shadow_reg[sr_reg[1:0]] <= sr_reg;
        else if (!sr_reg[2] && sr_reg[3])
          shadow_reg[5] <= sr_reg;
      end
    end
  end

  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  a_strobe_clk_low: assert property (latch_enable_in |-> !serial_clk)
    else $error("strobe high while serial clock high");
  a_clk_high_width: assert property ($rose(serial_clk) |-> serial_clk [*8] ##1 !serial_clk)
    else $error("serial clock high phase wrong length");
  a_clk_low_width: assert property ($fell(serial_clk) |-> !serial_clk [*8])
    else $error("serial clock low phase too short");
  a_data_stable_high: assert property ($rose(serial_clk) |-> $stable(serial_data) [*8])
    else $error("serial data moved while clock high");
  a_word_length: assert property ($rose(latch_enable_in) |-> cnt_reg == 6'h20)
    else $error("strobe not after 32 clock pulses");
  a_strobe_width: assert property ($rose(latch_enable_in) |=> latch_enable_in [*7] ##1 !latch_enable_in)
    else $error("strobe pulse wrong length");
  a_idle_pulse: assert property (rb_reg && fall && cnt_reg == 6'h01 |-> !readback_data)
    else $error("readback line active on idle pulse");
  a_readback_bits: assert property (rb_reg && known_reg && fall && cnt_reg >= 6'h02 |-> readback_data == word_reg[cnt_reg - 6'h02])
    else $error("readback bit differs from committed word");

  c_read_done: cover property (rb_reg && fall && cnt_reg == 6'h21);
  c_reg1_write: cover property ($rose(latch_enable_in) && sr_reg[1:0] == 2'h1);
  c_reg5_write: cover property ($rose(latch_enable_in) && sr_reg[3:0] == 4'h8);
endmodule : rscg_assertions

// ### tb/tb.sv
// self-checking bench: host and receiver joined over the link
`timescale 1ns/10ps
module tb;
  typedef struct {int sel; logic [31:0] v;} rscg_note_t;
  localparam logic [7:0] ID_VAL = 8'hC3; // arbitrary identification value
  logic clk_i;
  logic reset_i;
  logic [3:0] addr_i;
  logic [31:0] wdata_i;
  logic wr_i;
  logic rd_i;
  logic [31:0] rdata_o;
  logic fast_gain_pin_msb_i;
  logic fast_gain_pin_mid_i;
  logic fast_gain_pin_lsb_i;
  logic [7:0] dac_i_code_i;
  logic [7:0] dac_q_code_i;
  logic [4:0] baseband_gain_word_o;
  logic detector_resistor_bypass_o;
  logic detector_capacitor_bypass_o;
  logic [31:0] setup_reg1_o;
  logic [31:0] setup_reg2_o;
  logic [31:0] setup_reg3_o;
  logic [31:0] setup_reg5_o;
  logic readback_mode_o;
  logic watch;
  logic [31:0] lfsr;
  logic [31:0] obs;
  logic [31:0] wv [8];
  rscg_note_t exp_q [$];
  rscg_note_t nt;
  int errors;
  int n_compared;
  string names [8] = '{"rdata", "reg1", "reg2", "reg3", "mode", "reg5", "gain", "bypass"};

  rscg_link_if link ();
  rscg_host u_rscg_host (.clk_i, .reset_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .link(link));
  rscg_device #(.DEVICE_ID(ID_VAL)) u_rscg_device (.clk_i, .reset_i, .link(link),
    .fast_gain_pin_msb_i, .fast_gain_pin_mid_i, .fast_gain_pin_lsb_i, .dac_i_code_i,
    .dac_q_code_i, .baseband_gain_word_o, .detector_resistor_bypass_o,
    .detector_capacitor_bypass_o, .setup_reg1_o, .setup_reg2_o, .setup_reg3_o,
    .setup_reg5_o, .readback_mode_o);
  rscg_assertions u_rscg_assertions (.clk_i, .reset_i, .serial_clk(link.serial_clk),
    .serial_data(link.serial_data), .latch_enable_in(link.latch_enable_in),
    .readback_data(link.readback_data));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next

  // pins cut the serial gain, clamped at zero rather than wrapping
  function automatic logic [31:0] gain_of(input logic [4:0] g, input logic [2:0] p,
    input logic m);
    int r;
    r = int'(g) - int'(p) * (m ? 2 : 1);
    return (r < 0) ? 32'h0 : 32'(r);
  endfunction : gain_of

  task automatic final_report;
    if (errors == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : final_report

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] e);
    n_compared++;
    if (seen !== e)
    begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", nm, e, seen);
    end
  endtask : check

  // extra edge at the end keeps two strobe updates out of one time step
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
    @(posedge clk_i);
  endtask : wr

  task automatic rd(input logic [3:0] a, input bit chk, input logic [31:0] e,
    output logic [31:0] d);
    if (chk)
      exp_q.push_back('{0, e});
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    watch <= chk;
    @(negedge clk_i);
    d = rdata_o;
    @(posedge clk_i);
    watch <= 1'b0;
    @(posedge clk_i);
  endtask : rd

  task automatic note(input int s, input logic [31:0] e);
    exp_q.push_back('{s, e});
    watch <= 1'b1;
    @(posedge clk_i);
    watch <= 1'b0;
    @(posedge clk_i);
  endtask : note

  // bounded poll of the busy flag
  task automatic send(input logic [3:0] a, input logic [31:0] w);
    logic [31:0] s;
    wr(a, w);
    for (int i = 0; i < 1000; i++)
    begin
      rd(rscg_pkg::HOST_STAT_OFS, 1'b0, 32'h0, s);
      if (s[rscg_pkg::STAT_BUSY_BIT] === 1'b0)
        return;
    end
    errors++;
    final_report();
  endtask : send

  // ----------------------------------------------------------------
  // clock, monitor and stimulus
  // ----------------------------------------------------------------
  initial
  begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  // oldest note is judged against the output it names
  always @(negedge clk_i)
  begin
    if (watch === 1'b1 && exp_q.size() > 0)
    begin
      nt = exp_q.pop_front();
      case (nt.sel)
        0: obs = rdata_o;
        1: obs = setup_reg1_o;
        2: obs = setup_reg2_o;
        3: obs = setup_reg3_o;
        5: obs = setup_reg5_o;
        6: obs = {27'h0, baseband_gain_word_o};
        7: obs = {30'h0, detector_capacitor_bypass_o, detector_resistor_bypass_o};
        default: obs = {31'h0, readback_mode_o};
      endcase
      check(names[nt.sel], obs, nt.v);
    end
  end

  initial
  begin : main
    logic [31:0] d;
    logic [31:0] w;
    logic [4:0] g;
    logic [2:0] pv;
    logic m;
    reset_i = 1'b1;
    addr_i = 4'h0;
    wdata_i = 32'h0;
    wr_i = 1'b0;
    rd_i = 1'b0;
    watch = 1'b0;
    errors = 0;
    n_compared = 0;
    lfsr = lfsr_next(32'h5B08186B);
    {fast_gain_pin_msb_i, fast_gain_pin_mid_i, fast_gain_pin_lsb_i} = 3'h0;
    {dac_q_code_i, dac_i_code_i} = lfsr[15:0];
    wv = '{default: 32'h0};
    repeat (8) @(posedge clk_i);
    reset_i <= 1'b0;
    @(posedge clk_i);
    note(6, 32'h0);
    note(3, 32'h0);
    rd(4'h2, 1'b1, 32'h0, d);
    // gain word: low gain with doubled step, top gain, then a random one
    for (int k = 0; k < 3; k++)
    begin
      lfsr = lfsr_next(lfsr);
      g = (k == 0) ? 5'h03 : (k == 1) ? rscg_pkg::GAIN_MAX : 5'(lfsr % 25);
      m = (k != 1);
      w = (32'(g) << rscg_pkg::GAIN_LSB) | (32'(m) << rscg_pkg::FAST_MULT_BIT) | 32'h1
        | (32'(k[0]) << rscg_pkg::RES_BYP_BIT) | (32'(!k[0]) << rscg_pkg::CAP_BYP_BIT);
      send(rscg_pkg::HOST_TX_OFS, w);
      wv[1] = w;
      note(1, w);
      note(7, {30'h0, !k[0], k[0]});
      for (int p = 0; p < 9; p++)
      begin
        lfsr = lfsr_next(lfsr);
        pv = (p < 8) ? 3'(p) : lfsr[2:0];
        {fast_gain_pin_msb_i, fast_gain_pin_mid_i, fast_gain_pin_lsb_i} <= pv;
        repeat (4) @(posedge clk_i);
        note(6, gain_of(g, pv, m));
      end
    end
    // setup words for registers 2 and 3, then a word for the unused register, then register 5
    for (int a = 2; a < 6; a++)
    begin
      lfsr = lfsr_next(lfsr);
      w = (a == 5) ? {lfsr[31:4], 4'h8} : (a == 4) ? {lfsr[31:4], 4'h0} : {lfsr[31:2], 2'(a)};
      send(rscg_pkg::HOST_TX_OFS, w);
      if (a != 4)
        wv[a] = w;
      for (int s = 1; s < 6; s++)
        if (s != 4)
          note(s, wv[s]);
    end
    // readback of every selection, the read-only dac and id word first
    wv[0] = {8'h00, dac_q_code_i, dac_i_code_i, ID_VAL};
    wv[5] = (wv[5] == 32'h0) ? 32'h0 : wv[5];
    for (int s = 0; s < 8; s++)
    begin
      send(rscg_pkg::HOST_RB_OFS, {26'h0, 3'(s), 3'h4});
      rd(rscg_pkg::HOST_STAT_OFS, 1'b1, 32'h2, d);
      rd(rscg_pkg::HOST_RX_OFS, 1'b1, (s == 4 || s == 6) ? 32'h0 : wv[s], d);
      note(4, 32'h0);
    end
    final_report();
  end
endmodule : tb
